/* rtl/itf_decoder.sv */
// itf_decoder: decodes assignable input terminals into control requests.
// assumes terminal pins are asynchronous contacts; drive context comes from
// control logic on i_clk; bus master never strobes read and write together.
`timescale 1ns/100ps
// Contract
// - with third set input assigned, motor choice follows only the second-set input
// - set 1 both off, set 2 second only, set 3 when third on
// - converter-ready enable deasserted shuts off the power output
// - local panel mode change allowed only while interlock input on or unassigned; the switch input under operation mode 8 changes it regardless
// - PID enable input on runs PID, off runs normal operation
// - operation mode 8: switch input on external, off local panel
// - S-curve C select chooses stored set only when pattern equals 4
// - stopped with preexcite input on gives zero-speed control or lock
// - in position control preexcite input turns servo on and output on
// - output inhibit cuts power at once in every mode, motor coasts
// - output resumes about 20 ms after inhibit release
// - run commands are ignored while inhibit is active
// - self-hold latches momentary run; run with halt disables rotation
// - tuning request while stopped starts online tuning before run
// - preexcite plus run below starting speed also starts tuning
// - residual flux flag blocks the tuning request
// - run and preexcite inputs act only after tuning completes
// - during tuning only a restricted output function subset is allowed
// - tuning is disabled under volts-per-hertz control
// - two torque bias inputs select the bias amount when bias used
// - vector speed control: P-only input on gives P, off gives PI
// - brake-open input is passed as brake opening completion
// - general terminals default 0..3, reverse 9999 only there
// - second-set input selects the second parameter set unless the third-set input is on
module itf_decoder
#(
  parameter int RESUME_CYCLES = itf_pkg::ITF_RESUME_CYC
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // register port
  input wire logic [itf_pkg::ITF_ADDR_W-1:0] i_addr,
  input wire logic [itf_pkg::ITF_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [itf_pkg::ITF_DATA_W-1:0] o_rdata,
  // terminals and drive context
  input wire itf_pkg::itf_pins_t i_pins,
  input wire itf_pkg::itf_drive_t i_drive,
  // decoded control requests
  output itf_pkg::itf_ctrl_t o_ctrl
);
  import itf_pkg::*;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [4:0][13:0] codes;
    logic [7:0] opmode;
    logic [7:0] accel;
    logic ext_mode;
    logic latch_f;
    logic latch_r;
    logic [ITF_CNT_W-1:0] inh_cnt;
    itf_tune_t tune;
    logic [15:0] rdata;
    itf_ctrl_t ctrl;
  } itf_state_t;

  itf_state_t s;
  itf_state_t n;

  // terminal 4 is the reverse-run terminal, the only one allowed 9999
  function automatic logic fn_code_ok(input logic [15:0] c,
                                      input logic rev_term);
    logic [13:0] v;
    logic ok;
    v = c[13:0];
    ok = 1'b0;
    if (c[15:14] == 2'h0)
    begin
      ok = (v <= 14'h0003) || (v == 14'h0005) ||
           (v >= 14'h0008 && v <= 14'h0010) || (v == ITF_FC_SCURVE) ||
           (v >= 14'h0016 && v <= ITF_FC_TUNE) ||
           (v >= ITF_FC_TBIAS_A && v <= ITF_FC_P_ONLY) ||
           (rev_term && v == ITF_FC_REV_RUN);
    end
    return ok;
  endfunction : fn_code_ok

  function automatic logic fn_asg(input logic [4:0][13:0] codes,
                                  input logic [13:0] fc);
    logic hit;
    hit = 1'b0;
    for (int t = 0; t < 5; t++)
    begin
      hit = hit | (codes[t] == fc);
    end
    return hit;
  endfunction : fn_asg

  function automatic logic fn_on(input logic [4:0][13:0] codes,
                                 input logic [4:0] term,
                                 input logic [13:0] fc);
    logic hit;
    hit = 1'b0;
    for (int t = 0; t < 5; t++)
    begin
      hit = hit | ((codes[t] == fc) & term[t]);
    end
    return hit;
  endfunction : fn_on

  logic [4:0] term;
  logic fwd_in;
  logic rev_in;
  logic second_on;
  logic third_on;
  logic conv_ok;
  logic ilock_asg;
  logic ilock_on;
  logic pid_on;
  logic sw_asg;
  logic sw_on;
  logic sc_on;
  logic lx_on;
  logic inh_on;
  logic halt_asg;
  logic halt_on;
  logic tune_on;
  logic run_f;
  logic run_r;
  logic stopped;
  logic blocked;
  logic busy;
  logic start_req;
  logic lx_eff;
  logic local_req;
  logic [15:0] status;

  always_comb
  begin
    n = s;
    n.sync1 = {i_pins.fwd, i_pins.rev, i_pins.assignable};
    n.sync2 = s.sync1;
    term = s.sync2[4:0];
    fwd_in = s.sync2[5];
    rev_in = fn_on(s.codes, term, ITF_FC_REV_RUN);
    second_on = fn_on(s.codes, term, ITF_FC_SECOND);
    third_on = fn_on(s.codes, term, ITF_FC_THIRD);
    conv_ok = !fn_asg(s.codes, ITF_FC_CONV_RDY) ||
              fn_on(s.codes, term, ITF_FC_CONV_RDY);
    ilock_asg = fn_asg(s.codes, ITF_FC_INTERLOCK);
    ilock_on = fn_on(s.codes, term, ITF_FC_INTERLOCK);
    pid_on = fn_on(s.codes, term, ITF_FC_PID);
    sw_asg = fn_asg(s.codes, ITF_FC_PANEL_EXT);
    sw_on = fn_on(s.codes, term, ITF_FC_PANEL_EXT);
    sc_on = fn_on(s.codes, term, ITF_FC_SCURVE);
    lx_on = fn_on(s.codes, term, ITF_FC_PREEXCITE);
    inh_on = fn_on(s.codes, term, ITF_FC_INHIBIT);
    halt_asg = fn_asg(s.codes, ITF_FC_SELF_HOLD);
    halt_on = fn_on(s.codes, term, ITF_FC_SELF_HOLD);
    tune_on = fn_on(s.codes, term, ITF_FC_TUNE);
    busy = (s.tune == ITF_TS_BUSY);

    // self-hold: a momentary press latches, halt releases and overrides
    if (halt_asg)
    begin
      n.latch_f = (s.latch_f | fwd_in) & ~halt_on & ~inh_on;
      n.latch_r = (s.latch_r | rev_in) & ~halt_on & ~inh_on;
      run_f = s.latch_f & ~halt_on;
      run_r = s.latch_r & ~halt_on;
    end
    else
    begin
      n.latch_f = 1'b0;
      n.latch_r = 1'b0;
      run_f = fwd_in;
      run_r = rev_in;
    end
    stopped = ~run_f & ~run_r;

    // inhibit: hold-off counter restarts on every active cycle
    if (inh_on)
    begin
      n.inh_cnt = ITF_CNT_W'(RESUME_CYCLES);
    end
    else if (s.inh_cnt != '0)
    begin
      n.inh_cnt = s.inh_cnt - 1'b1;
    end
    blocked = inh_on | (s.inh_cnt != '0);

    // start-time tuning
    start_req = ~i_drive.vf_control & ~i_drive.residual_flux_flag &
                ((tune_on & stopped) |
                 (lx_on & ~stopped & i_drive.speed_below_start));
    unique case (s.tune)
      ITF_TS_IDLE:
      begin
        if (start_req)
        begin
          n.tune = ITF_TS_BUSY;
        end
      end
      ITF_TS_BUSY:
      begin
        if (i_drive.tune_done || i_drive.vf_control)
        begin
          n.tune = ITF_TS_IDLE;
        end
      end
    endcase

    // operation mode selection
    local_req = i_wr && (i_addr == ITF_OFS_CTRL) && i_wdata[ITF_CTRL_LOCAL];
    if ((s.opmode == ITF_OPMODE_SWITCH) && sw_asg)
    begin
      n.ext_mode = sw_on;
    end
    else if (local_req)
    begin
      if (!ilock_asg || ilock_on)
      begin
        n.ext_mode = 1'b0;
      end
    end
    else if (i_wr && (i_addr == ITF_OFS_CTRL) && i_wdata[ITF_CTRL_EXT])
    begin
      n.ext_mode = 1'b1;
    end

    // decoded outputs
    lx_eff = lx_on & ~busy;
    n.ctrl.motor2_sel = second_on;
    if (third_on)
    begin
      n.ctrl.param_set = ITF_SET3;
    end
    else if (second_on)
    begin
      n.ctrl.param_set = ITF_SET2;
    end
    else
    begin
      n.ctrl.param_set = ITF_SET1;
    end
    n.ctrl.servo_on = lx_eff & i_drive.position_ctrl;
    n.ctrl.zero_speed_lock = lx_eff & ~i_drive.position_ctrl & stopped;
    n.ctrl.power_on = ~blocked & conv_ok &
                      (~i_drive.position_ctrl | n.ctrl.servo_on);
    n.ctrl.coast = blocked;
    n.ctrl.pid_run = pid_on;
    n.ctrl.brake_open_done = fn_on(s.codes, term, ITF_FC_BRAKE);
    n.ctrl.local_panel_mode = ~s.ext_mode;
    n.ctrl.scurve_set2 = (s.accel == ITF_ACCEL_SCURVE_C) & sc_on;
    n.ctrl.run_fwd = run_f & ~blocked & ~busy;
    n.ctrl.run_rev = run_r & ~blocked & ~busy;
    n.ctrl.tuning = busy;
    n.ctrl.torque_bias_sel = i_drive.torque_bias_en ?
      {fn_on(s.codes, term, ITF_FC_TBIAS_B),
       fn_on(s.codes, term, ITF_FC_TBIAS_A)} : 2'h0;
    n.ctrl.p_only = i_drive.vector_speed &
                    fn_on(s.codes, term, ITF_FC_P_ONLY);
    n.ctrl.out_allow = busy ? ITF_TUNE_OUT_MASK : ITF_ALL_OUT_MASK;

    // register writes; an illegal function code leaves the old one
    if (i_wr)
    begin
      unique case (i_addr)
        ITF_OFS_CODE0, ITF_OFS_CODE1, ITF_OFS_CODE2, ITF_OFS_CODE3,
        ITF_OFS_CODE_REV:
        begin
          if (fn_code_ok(i_wdata, i_addr == ITF_OFS_CODE_REV))
          begin
            n.codes[i_addr[2:0]] = i_wdata[13:0];
          end
        end
        ITF_OFS_OPMODE:
        begin
          n.opmode = i_wdata[7:0];
        end
        ITF_OFS_ACCEL:
        begin
          n.accel = i_wdata[7:0];
        end
        default:
        begin
        end
      endcase
    end

    status = 16'h0000;
    status[ITF_ST_EXT] = s.ext_mode;
    status[ITF_ST_BUSY] = busy;
    status[ITF_ST_POWER] = s.ctrl.power_on;
    status[ITF_ST_INHIBIT] = blocked;
    status[ITF_ST_RUN_F] = s.ctrl.run_fwd;
    status[ITF_ST_RUN_R] = s.ctrl.run_rev;
    status[ITF_ST_SET_LO +: 2] = s.ctrl.param_set;
    status[ITF_ST_MOTOR2] = s.ctrl.motor2_sel;

    // read data stand only in the cycle after the strobe
    n.rdata = 16'h0000;
    if (i_rd)
    begin
      unique case (i_addr)
        ITF_OFS_CODE0, ITF_OFS_CODE1, ITF_OFS_CODE2, ITF_OFS_CODE3,
        ITF_OFS_CODE_REV:
        begin
          n.rdata = {2'h0, s.codes[i_addr[2:0]]};
        end
        ITF_OFS_OPMODE:
        begin
          n.rdata = {8'h00, s.opmode};
        end
        ITF_OFS_ACCEL:
        begin
          n.rdata = {8'h00, s.accel};
        end
        ITF_OFS_STATUS:
        begin
          n.rdata = status;
        end
        default:
        begin
          n.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s <= '0;
      s.codes[0] <= ITF_CODE0_RST;
      s.codes[1] <= ITF_CODE1_RST;
      s.codes[2] <= ITF_CODE2_RST;
      s.codes[3] <= ITF_CODE3_RST;
      s.codes[4] <= ITF_CODE_REV_RST;
      s.opmode <= ITF_OPMODE_RST;
      s.accel <= ITF_ACCEL_RST;
      s.ext_mode <= ITF_EXT_MODE_RST;
      s.ctrl.local_panel_mode <= ~ITF_EXT_MODE_RST;
      s.ctrl.out_allow <= ITF_ALL_OUT_MASK;
    end
    else
    begin
      s <= n;
    end
  end

  assign o_rdata = s.rdata;
  assign o_ctrl = s.ctrl;

  sequence tune_entry_s;
    (s.tune == ITF_TS_IDLE) && start_req;
  endsequence

  sequence local_refused_s;
    local_req && ilock_asg && !ilock_on &&
    !((s.opmode == ITF_OPMODE_SWITCH) && sw_asg);
  endsequence

  param_set3_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    third_on |=> (o_ctrl.param_set == ITF_SET3) &&
                 (o_ctrl.motor2_sel == $past(second_on)))
    else $error("third set or motor choice wrong");
  motor_follow_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (third_on && !second_on) |=> !o_ctrl.motor2_sel)
    else $error("motor not first with second input off");
  panel_refuse_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    local_refused_s |=> $stable(s.ext_mode))
    else $error("local panel change taken without interlock");
  inhibit_cut_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    inh_on |=> !o_ctrl.power_on && o_ctrl.coast && !o_ctrl.run_fwd)
    else $error("power not cut on inhibit");
  resume_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $fell(inh_on) |-> (s.inh_cnt == ITF_CNT_W'(RESUME_CYCLES)) ##1
      (!o_ctrl.power_on && !o_ctrl.run_rev))
    else $error("output resumed before hold-off");
  tune_start_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    tune_entry_s |=> (s.tune == ITF_TS_BUSY) ##1 o_ctrl.tuning)
    else $error("tuning did not start");
  flux_block_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ((s.tune == ITF_TS_IDLE) && i_drive.residual_flux_flag) |=>
      (s.tune == ITF_TS_IDLE))
    else $error("tuning started with residual flux");
  tune_gate_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    busy |=> !o_ctrl.run_fwd && !o_ctrl.run_rev && !o_ctrl.servo_on &&
             (o_ctrl.out_allow == ITF_TUNE_OUT_MASK))
    else $error("commands or outputs acted on during tuning");
  vf_no_tune_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_drive.vf_control |=> (s.tune == ITF_TS_IDLE))
    else $error("tuning active under v/f control");
  scurve_sel_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (s.accel != ITF_ACCEL_SCURVE_C) |=> !o_ctrl.scurve_set2)
    else $error("s-curve select used with wrong pattern");
  pid_follow_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 (o_ctrl.pid_run == $past(pid_on)))
    else $error("pid request does not follow input");
  halt_stop_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    halt_on |=> !o_ctrl.run_fwd && !o_ctrl.run_rev && !s.latch_f)
    else $error("rotation not disabled by halt");
endmodule : itf_decoder

/* rtl/itf_pkg.sv */
// itf_pkg: constants, types and register map of the input terminal decoder.
// assumes a single 10 MHz control clock shared by the bus and the block.
package itf_pkg;
  // register port
  localparam int ITF_ADDR_W = 4;
  localparam int ITF_DATA_W = 16;
  localparam logic [3:0] ITF_OFS_CODE0 = 4'h0;
  localparam logic [3:0] ITF_OFS_CODE1 = 4'h1;
  localparam logic [3:0] ITF_OFS_CODE2 = 4'h2;
  localparam logic [3:0] ITF_OFS_CODE3 = 4'h3;
  localparam logic [3:0] ITF_OFS_CODE_REV = 4'h4;
  localparam logic [3:0] ITF_OFS_OPMODE = 4'h5;
  localparam logic [3:0] ITF_OFS_ACCEL = 4'h6;
  localparam logic [3:0] ITF_OFS_CTRL = 4'h7;
  localparam logic [3:0] ITF_OFS_STATUS = 4'h8;
  // control register bits (write one to request)
  localparam int ITF_CTRL_LOCAL = 0;
  localparam int ITF_CTRL_EXT = 1;
  // status register bits
  localparam int ITF_ST_EXT = 0;
  localparam int ITF_ST_BUSY = 1;
  localparam int ITF_ST_POWER = 2;
  localparam int ITF_ST_INHIBIT = 3;
  localparam int ITF_ST_RUN_F = 4;
  localparam int ITF_ST_RUN_R = 5;
  localparam int ITF_ST_SET_LO = 6;
  localparam int ITF_ST_MOTOR2 = 8;
  // terminal function codes
  localparam int ITF_CODE_W = 14;
  localparam logic [13:0] ITF_FC_SECOND = 14'h0003;
  localparam logic [13:0] ITF_FC_THIRD = 14'h0009;
  localparam logic [13:0] ITF_FC_CONV_RDY = 14'h000A;
  localparam logic [13:0] ITF_FC_INTERLOCK = 14'h000C;
  localparam logic [13:0] ITF_FC_PID = 14'h000E;
  localparam logic [13:0] ITF_FC_BRAKE = 14'h000F;
  localparam logic [13:0] ITF_FC_PANEL_EXT = 14'h0010;
  localparam logic [13:0] ITF_FC_SCURVE = 14'h0014;
  localparam logic [13:0] ITF_FC_PREEXCITE = 14'h0017;
  localparam logic [13:0] ITF_FC_INHIBIT = 14'h0018;
  localparam logic [13:0] ITF_FC_SELF_HOLD = 14'h0019;
  localparam logic [13:0] ITF_FC_TUNE = 14'h001C;
  localparam logic [13:0] ITF_FC_TBIAS_A = 14'h002A;
  localparam logic [13:0] ITF_FC_TBIAS_B = 14'h002B;
  localparam logic [13:0] ITF_FC_P_ONLY = 14'h002C;
  localparam logic [13:0] ITF_FC_REV_RUN = 14'h270F;
  // reset values
  localparam logic [13:0] ITF_CODE0_RST = 14'h0000;
  localparam logic [13:0] ITF_CODE1_RST = 14'h0001;
  localparam logic [13:0] ITF_CODE2_RST = 14'h0002;
  localparam logic [13:0] ITF_CODE3_RST = 14'h0003;
  localparam logic [13:0] ITF_CODE_REV_RST = 14'h270F;
  localparam logic [7:0] ITF_OPMODE_RST = 8'h00;
  localparam logic [7:0] ITF_ACCEL_RST = 8'h00;
  localparam logic ITF_EXT_MODE_RST = 1'b1;
  // parameter values that unlock terminal functions
  localparam logic [7:0] ITF_OPMODE_SWITCH = 8'h08;
  localparam logic [7:0] ITF_ACCEL_SCURVE_C = 8'h04;
  // parameter sets
  localparam logic [1:0] ITF_SET1 = 2'h0;
  localparam logic [1:0] ITF_SET2 = 2'h1;
  localparam logic [1:0] ITF_SET3 = 2'h2;
  // output functions allowed during tuning: bit0 power failure, bit1 thermal
  // prealarm, bit2 panel mode, bit3 current detect, bit4 ready, bit5 fault,
  // bit6 analog monitors
  localparam int ITF_OUTF_W = 16;
  localparam logic [15:0] ITF_TUNE_OUT_MASK = 16'h007F;
  localparam logic [15:0] ITF_ALL_OUT_MASK = 16'hFFFF;
  // timing
  localparam int ITF_CLK_HZ = 10_000_000;
  localparam int ITF_RESUME_MS = 20;
  localparam int ITF_RESUME_CYC = ITF_RESUME_MS * (ITF_CLK_HZ / 1000);
  localparam int ITF_CNT_W = 18;

  typedef enum logic {ITF_TS_IDLE, ITF_TS_BUSY} itf_tune_t;

  typedef struct packed {
    logic fwd;
    logic rev;
    logic [3:0] assignable;
  } itf_pins_t;

  typedef struct packed {
    logic vf_control;
    logic position_ctrl;
    logic vector_speed;
    logic torque_bias_en;
    logic speed_below_start;
    logic residual_flux_flag;
    logic tune_done;
  } itf_drive_t;

  typedef struct packed {
    logic motor2_sel;
    logic [1:0] param_set;
    logic power_on;
    logic coast;
    logic pid_run;
    logic brake_open_done;
    logic local_panel_mode;
    logic scurve_set2;
    logic zero_speed_lock;
    logic servo_on;
    logic run_fwd;
    logic run_rev;
    logic tuning;
    logic [1:0] torque_bias_sel;
    logic p_only;
    logic [15:0] out_allow;
  } itf_ctrl_t;
endpackage : itf_pkg

/* bench/itf_terminal_model.sv */
// itf_terminal_model: external contacts or a controller driving terminals.
// assumes the bench sets the wanted levels by nba on the rising clock edge.
`timescale 1ns/100ps
module itf_terminal_model
(
  // clock
  input wire logic i_clk,
  // wanted contact levels
  input wire itf_pkg::itf_pins_t i_want,
  // terminal levels seen by the device
  output itf_pkg::itf_pins_t o_pins
);
  import itf_pkg::*;

  // contacts settle a cycle after the command, as a relay would
  always_ff @(posedge i_clk)
    o_pins <= i_want;
endmodule : itf_terminal_model

/* bench/itf_decoder_test.sv */
// itf_decoder_test: self-checking bench for the terminal decoder.
// assumes the terminal model in front of the pins and a 10 MHz clock.
`timescale 1ns/100ps
module itf_decoder_test;
  import itf_pkg::*;
  // short hold-off keeps the inhibit release test quick
  localparam int RES = 10;
  logic i_clk, i_reset_n, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata, rdat;
  itf_pins_t want, pins;
  itf_drive_t drv, nd;
  itf_ctrl_t ctl;
  int fail_count, check_count, cyc;
  logic [31:0] rng;
  logic [13:0] fcs [5];

  itf_terminal_model itf_terminal_model_i (.i_clk(i_clk), .i_want(want),
    .o_pins(pins));
  itf_decoder #(.RESUME_CYCLES(RES)) itf_decoder_i (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pins(pins),
    .i_drive(drv), .o_ctrl(ctl));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [1:0] exp_set(input logic sec, input logic thr);
    return thr ? ITF_SET3 : (sec ? ITF_SET2 : ITF_SET1);
  endfunction : exp_set

  function automatic logic fbit(input int k);
    case (k)
      0: return ctl.pid_run;
      1: return ctl.brake_open_done;
      2: return ctl.p_only;
      3: return ctl.torque_bias_sel[0];
      default: return ctl.torque_bias_sel[1];
    endcase
  endfunction : fbit

  task automatic close_out;
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1;
    rdat = o_rdata;
  endtask : rd

  // pins pass the model flop and the two-flop sync before decode
  task automatic pin(input logic [3:0] a, input logic f);
    @(posedge i_clk);
    want.assignable <= a;
    want.fwd <= f;
    step(6);
  endtask : pin

  task automatic dr(input itf_drive_t d);
    @(posedge i_clk);
    drv <= d;
    step(3);
  endtask : dr

  initial
  begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc >= 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    i_reset_n = 1'h0;
    i_wr = 1'h0;
    i_rd = 1'h0;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    want = '0;
    drv = '0;
    rng = 32'hE623;
    fcs = '{ITF_FC_PID, ITF_FC_BRAKE, ITF_FC_P_ONLY, ITF_FC_TBIAS_A,
      ITF_FC_TBIAS_B};
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'h1;
    step(6);
    for (int i = 0; i < 5; i++)
    begin
      rd(i[3:0]);
      chk(rdat, (i == 4) ? 16'h270F : i[15:0]);
    end
    rd(ITF_OFS_OPMODE);
    chk(rdat, 16'h0000);
    rd(4'hF);
    chk(rdat, 16'h0000);
    rd(ITF_OFS_STATUS);
    chk(rdat, 16'h0005);
    chk(ctl.out_allow, ITF_ALL_OUT_MASK);
    // 9999 only on the reverse terminal, unlisted codes refused
    wr(ITF_OFS_CODE0, 16'h270F);
    wr(ITF_OFS_CODE1, 16'h0004);
    wr(ITF_OFS_CODE_REV, 16'h0003);
    rd(ITF_OFS_CODE0);
    chk(rdat, 16'h0000);
    rd(ITF_OFS_CODE1);
    chk(rdat, 16'h0001);
    rd(ITF_OFS_CODE_REV);
    chk(rdat, 16'h0003);
    wr(ITF_OFS_CODE_REV, 16'h270F);
    // terminal 3 keeps second-set code, terminal 2 takes the third
    wr(ITF_OFS_CODE2, 16'h0009);
    for (int i = 0; i < 4; i++)
    begin
      pin({i[0], i[1], 2'h0}, 1'h0);
      chk(16'(ctl.param_set), 16'(exp_set(i[0], i[1])));
      chk(16'(ctl.motor2_sel), 16'(i[0]));
      rd(ITF_OFS_STATUS);
      chk(rdat, 16'h0005 | {7'h00, i[0], exp_set(i[0], i[1]), 6'h00});
    end
    pin(4'h0, 1'h0);
    wr(ITF_OFS_CODE2, 16'h0002);
    nd = drv;
    nd.vector_speed = 1'h1;
    nd.torque_bias_en = 1'h1;
    dr(nd);
    for (int k = 0; k < 5; k++)
    begin
      wr(ITF_OFS_CODE0, {2'h0, fcs[k]});
      for (int j = 0; j < 6; j++)
      begin
        rng = xs(rng);
        pin(rng[3:0], 1'h0);
        chk(16'(fbit(k)), 16'(rng[0]));
      end
    end
    pin(4'hF, 1'h0);
    wr(ITF_OFS_CODE0, 16'h0000);
    step(4);
    chk(16'({ctl.pid_run, ctl.p_only, ctl.torque_bias_sel}), 16'h0000);
    pin(4'h0, 1'h0);
    dr('0);
    // panel mode interlock, then switch input under opmode 8
    wr(ITF_OFS_CODE0, 16'h000C);
    wr(ITF_OFS_CTRL, 16'h0001);
    step(2);
    chk(16'(ctl.local_panel_mode), 16'h0000);
    pin(4'h1, 1'h0);
    wr(ITF_OFS_CTRL, 16'h0001);
    step(2);
    chk(16'(ctl.local_panel_mode), 16'h0001);
    wr(ITF_OFS_CTRL, 16'h0002);
    step(2);
    chk(16'(ctl.local_panel_mode), 16'h0000);
    wr(ITF_OFS_CODE0, 16'h0010);
    wr(ITF_OFS_OPMODE, 16'h0008);
    pin(4'h0, 1'h0);
    chk(16'(ctl.local_panel_mode), 16'h0001);
    pin(4'h1, 1'h0);
    chk(16'(ctl.local_panel_mode), 16'h0000);
    wr(ITF_OFS_OPMODE, 16'h0000);
    // s-curve select only with pattern 4
    wr(ITF_OFS_CODE0, 16'h0014);
    step(4);
    chk(16'(ctl.scurve_set2), 16'h0000);
    wr(ITF_OFS_ACCEL, 16'h0004);
    step(2);
    chk(16'(ctl.scurve_set2), 16'h0001);
    wr(ITF_OFS_ACCEL, 16'h0000);
    // converter ready off shuts the output
    wr(ITF_OFS_CODE0, 16'h000A);
    pin(4'h0, 1'h0);
    chk(16'(ctl.power_on), 16'h0000);
    pin(4'h1, 1'h0);
    step(20);
    chk(16'(ctl.power_on), 16'h0001);
    // output inhibit with a run request pending
    wr(ITF_OFS_CODE0, 16'h0018);
    pin(4'h1, 1'h0);
    chk(16'({ctl.power_on, ctl.coast}), 16'h0001);
    pin(4'h1, 1'h1);
    chk(16'(ctl.run_fwd), 16'h0000);
    pin(4'h0, 1'h1);
    chk(16'(ctl.power_on), 16'h0000);
    step(15);
    chk(16'({ctl.power_on, ctl.run_fwd}), 16'h0003);
    pin(4'h0, 1'h0);
    // self-hold latch, halt releases and blocks
    wr(ITF_OFS_CODE0, 16'h0019);
    pin(4'h0, 1'h1);
    pin(4'h0, 1'h0);
    chk(16'(ctl.run_fwd), 16'h0001);
    pin(4'h1, 1'h0);
    chk(16'(ctl.run_fwd), 16'h0000);
    pin(4'h1, 1'h1);
    chk(16'(ctl.run_fwd), 16'h0000);
    pin(4'h0, 1'h0);
    // start-time tuning and what blocks it
    wr(ITF_OFS_CODE0, 16'h001C);
    pin(4'h1, 1'h0);
    chk(16'(ctl.tuning), 16'h0001);
    chk(ctl.out_allow, ITF_TUNE_OUT_MASK);
    pin(4'h0, 1'h1);
    chk(16'(ctl.run_fwd), 16'h0000);
    nd = '0;
    nd.tune_done = 1'h1;
    dr(nd);
    dr('0);
    step(3);
    chk(16'({ctl.tuning, ctl.run_fwd}), 16'h0001);
    chk(ctl.out_allow, ITF_ALL_OUT_MASK);
    pin(4'h0, 1'h0);
    nd = '0;
    nd.residual_flux_flag = 1'h1;
    dr(nd);
    pin(4'h1, 1'h0);
    chk(16'(ctl.tuning), 16'h0000);
    pin(4'h0, 1'h0);
    nd = '0;
    nd.vf_control = 1'h1;
    dr(nd);
    pin(4'h1, 1'h0);
    chk(16'(ctl.tuning), 16'h0000);
    pin(4'h0, 1'h0);
    dr('0);
    // reverse run comes only from the terminal coded 9999
    @(posedge i_clk);
    want.rev <= 1'h1;
    step(6);
    chk(16'({ctl.run_rev, ctl.run_fwd}), 16'h0002);
    @(posedge i_clk);
    want.rev <= 1'h0;
    step(6);
    // pre-excitation and servo on
    wr(ITF_OFS_CODE0, 16'h0017);
    pin(4'h1, 1'h0);
    chk(16'(ctl.zero_speed_lock), 16'h0001);
    nd = '0;
    nd.position_ctrl = 1'h1;
    dr(nd);
    chk(16'({ctl.servo_on, ctl.power_on}), 16'h0003);
    pin(4'h0, 1'h0);
    chk(16'({ctl.servo_on, ctl.power_on}), 16'h0000);
    nd = '0;
    nd.speed_below_start = 1'h1;
    dr(nd);
    pin(4'h1, 1'h1);
    chk(16'(ctl.tuning), 16'h0001);
    pin(4'h0, 1'h0);
    close_out();
  end
endmodule : itf_decoder_test
